// *** logic/irqfp_pkg.sv ***
// irqfp_pkg: constants and types of the interrupt flag and priority block
// assumes 8-bit registers, one per aligned 32-bit word on the register bus
package irqfp_pkg;
  localparam int ADDR_W = 8;
  localparam int VEC_W = 21;
  localparam int EXT_N = 3;
  typedef enum logic [2:0] {
    CCP_CAPTURE = 3'h1,
    CCP_COMPARE = 3'h2,
    CCP_PWM = 3'h4
  } irqfp_ccp_mode_type;
  // register indices; byte address is four times the index
  localparam logic [5:0] IDX_ECTL = 6'h00, IDX_XCTL = 6'h01, IDX_RCTL = 6'h02;
  localparam logic [5:0] IDX_PFA = 6'h03, IDX_PFB = 6'h04, IDX_CORE = 6'h05;
  localparam logic [5:0] IDX_PENA = 6'h06, IDX_PENB = 6'h07;
  localparam logic [5:0] IDX_PPRA = 6'h08, IDX_PPRB = 6'h09, IDX_LAST = 6'h09;
  localparam logic [1:0] ALIGN_OK = 2'h0;
  // implemented bits of each register
  localparam logic [7:0] MASK_ECTL = 8'hF5, MASK_XCTL = 8'hDB, MASK_RCTL = 8'h9E;
  localparam logic [7:0] MASK_PFA = 8'h7F, MASK_PFB = 8'h0F, MASK_CORE = 8'hD2;
  localparam logic [7:0] WMASK_PFA = 8'h4F;
  localparam logic [7:0] RST_ECTL = 8'hF5, RST_XCTL = 8'hC0, RST_RCTL = 8'h1C;
  localparam logic [7:0] RST_ZERO = 8'h00, RST_PPRA = 8'h7F, RST_PPRB = 8'h0F;
  // field positions
  localparam int PULLUP_DIS = 7, EDGE0 = 6, EDGE1 = 5, EDGE2 = 4, T0_PRIO = 2, PC_PRIO = 0;
  localparam int X2_PRIO = 7, X1_PRIO = 6, X2_EN = 4, X1_EN = 3, X2_FLAG = 1, X1_FLAG = 0;
  localparam int PRIO_ON = 7;
  localparam int GLB_EN = 7, GRP_EN = 6, X0_EN = 4, X0_FLAG = 1;
  localparam int AD_B = 6, RX_B = 5, TX_B = 4, SSP_B = 3, CCP1_B = 2, T2_B = 1, T1_B = 0;
  localparam int BCL_B = 3, LVD_B = 2, T3_B = 1, CCP2_B = 0;
  localparam logic [VEC_W-1:0] VEC_HIGH = 21'h000008;
  localparam logic [VEC_W-1:0] VEC_LOW = 21'h000018;
  localparam logic [1:0] RESP_OKAY = 2'h0, RESP_SLVERR = 2'h2;
endpackage

// *** logic/irqfp_reg_if.sv ***
// irqfp_reg_if: register access strobes between bus slave and register file
// assumes both ends on aclk; rd_data is combinational from rd_idx
`timescale 1ns/1ps
`default_nettype none
interface irqfp_reg_if;
  logic wr_en;
  logic [5:0] wr_idx;
  logic [7:0] wr_data;
  logic [5:0] rd_idx;
  logic [7:0] rd_data;
  modport bus (output wr_en, wr_idx, wr_data, rd_idx, input rd_data);
  modport regs (input wr_en, wr_idx, wr_data, rd_idx, output rd_data);
endinterface
`default_nettype wire

// *** logic/irqfp_axil.sv ***
// irqfp_axil: AXI4-Lite slave turning bus transfers into register strobes
// assumes one write and one read outstanding at most; lane 0 carries data
`timescale 1ns/1ps
`default_nettype none
module irqfp_axil (
  input wire logic aclk, // system clock
  input wire logic aresetn, // sync reset, low
  input wire logic [irqfp_pkg::ADDR_W-1:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // byte strobes
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [irqfp_pkg::ADDR_W-1:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready, // read data ready
  irqfp_reg_if.bus rif // register strobes
);
  logic aw_full_q, w_full_q, wlane_q, bvalid_q, rvalid_q;
  logic [irqfp_pkg::ADDR_W-1:0] awaddr_q;
  logic [7:0] wbyte_q;
  logic [1:0] bresp_q, rresp_q;
  logic [31:0] rdata_q;
  logic do_write, aw_ok, ar_ok;

  assign s_axi_awready = !aw_full_q;
  assign s_axi_wready = !w_full_q;
  assign s_axi_arready = !rvalid_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rresp = rresp_q;
  assign s_axi_rdata = rdata_q;
  assign do_write = aw_full_q && w_full_q && !bvalid_q;
  assign aw_ok = (awaddr_q[1:0] == irqfp_pkg::ALIGN_OK) && (awaddr_q[7:2] <= irqfp_pkg::IDX_LAST);
  assign ar_ok = (s_axi_araddr[1:0] == irqfp_pkg::ALIGN_OK)
                 && (s_axi_araddr[7:2] <= irqfp_pkg::IDX_LAST);
  // a write without lane 0 is answered but changes nothing
  assign rif.wr_en = do_write && aw_ok && wlane_q;
  assign rif.wr_idx = awaddr_q[7:2];
  assign rif.wr_data = wbyte_q;
  assign rif.rd_idx = s_axi_araddr[7:2];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
      awaddr_q <= '0;
      wbyte_q <= '0;
      wlane_q <= 1'b0;
    end else begin
      if (s_axi_awvalid && !aw_full_q) begin
        aw_full_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end else if (do_write) begin
        aw_full_q <= 1'b0;
      end
      if (s_axi_wvalid && !w_full_q) begin
        w_full_q <= 1'b1;
        wbyte_q <= s_axi_wdata[7:0];
        wlane_q <= s_axi_wstrb[0];
      end else if (do_write) begin
        w_full_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q <= irqfp_pkg::RESP_OKAY;
    end else if (do_write) begin
      bvalid_q <= 1'b1;
      bresp_q <= aw_ok ? irqfp_pkg::RESP_OKAY : irqfp_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rresp_q <= irqfp_pkg::RESP_OKAY;
      rdata_q <= '0;
    end else if (s_axi_arvalid && !rvalid_q) begin
      rvalid_q <= 1'b1;
      rresp_q <= ar_ok ? irqfp_pkg::RESP_OKAY : irqfp_pkg::RESP_SLVERR;
      rdata_q <= ar_ok ? {24'h000000, rif.rd_data} : 32'h00000000;
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// *** logic/irqfp_top.sv ***
// irqfp_top: interrupt flags, enables, priorities and vector request
// assumes peripheral event inputs are one-cycle aclk pulses; ext_pin async
//
// Chosen here: the address map and the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module irqfp_top (
  input wire logic aclk, // system clock, 200 MHz
  input wire logic aresetn, // sync reset, low
  input wire logic [irqfp_pkg::ADDR_W-1:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // byte strobes
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [irqfp_pkg::ADDR_W-1:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready, // read data ready
  input wire logic [irqfp_pkg::EXT_N-1:0] ext_pin, // external interrupt pins
  input wire logic [7:0] portb_latch, // port-B output latch
  output logic [7:0] portb_pullup_en, // port-B weak pull-up on
  input wire logic timer0_ovf_req, // timer-0 flag and enable, level
  input wire logic port_change_req, // port-change flag and enable, level
  input wire logic adc_done, // conversion finished, pulse
  input wire logic rx_buffer_full, // serial receive buffer holds data
  input wire logic tx_buffer_empty, // serial transmit buffer empty
  input wire logic sync_serial_done, // sync serial transfer done, pulse
  input wire irqfp_pkg::irqfp_ccp_mode_type ccp1_mode, // unit-1 mode
  input wire logic ccp1_capture, // unit-1 capture, pulse
  input wire logic ccp1_match, // unit-1 compare match, pulse
  input wire logic timer2_match, // timer-2 equals period, pulse
  input wire logic timer1_ovf, // timer-1 overflow, pulse
  input wire logic bus_collision, // bus collision, pulse
  input wire logic low_voltage, // low-voltage detect, pulse
  input wire logic timer3_ovf, // timer-3 overflow, pulse
  input wire irqfp_pkg::irqfp_ccp_mode_type ccp2_mode, // unit-2 mode
  input wire logic ccp2_capture, // unit-2 capture, pulse
  input wire logic ccp2_match, // unit-2 compare match, pulse
  input wire logic irq_ack, // core accepts the request, pulse
  output logic irq_req, // interrupt request to core
  output logic irq_high, // request is high level
  output logic [irqfp_pkg::VEC_W-1:0] irq_vector // vector address
);
  irqfp_reg_if rif ();

  irqfp_axil u_axil (
    .aclk(aclk),
    .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .rif(rif.bus)
  );

  logic [7:0] ectl_q, xctl_q, rctl_q, pfa_q, pfb_q, core_q;
  logic [7:0] pena_q, penb_q, ppra_q, pprb_q;
  logic [7:0] core_d, pfa_full, pfa_set, pfb_set, xset;
  logic wr_ectl, wr_xctl, wr_rctl, wr_pfa, wr_pfb, wr_core;
  logic wr_pena, wr_penb, wr_ppra, wr_pprb;
  logic [irqfp_pkg::EXT_N-1:0] ext_evt, edge_sel, ext_pend;
  logic [4:0] core_pend, core_prio;
  logic [15:0] per_pend, per_prio;
  logic prio_on, hi_any, lo_any, req_hi, req_lo, accept;
  logic irq_req_q, irq_high_q;
  logic [irqfp_pkg::VEC_W-1:0] irq_vector_q;

  assign wr_ectl = rif.wr_en && (rif.wr_idx == irqfp_pkg::IDX_ECTL);
  assign wr_xctl = rif.wr_en && (rif.wr_idx == irqfp_pkg::IDX_XCTL);
  assign wr_rctl = rif.wr_en && (rif.wr_idx == irqfp_pkg::IDX_RCTL);
  assign wr_pfa = rif.wr_en && (rif.wr_idx == irqfp_pkg::IDX_PFA);
  assign wr_pfb = rif.wr_en && (rif.wr_idx == irqfp_pkg::IDX_PFB);
  assign wr_core = rif.wr_en && (rif.wr_idx == irqfp_pkg::IDX_CORE);
  assign wr_pena = rif.wr_en && (rif.wr_idx == irqfp_pkg::IDX_PENA);
  assign wr_penb = rif.wr_en && (rif.wr_idx == irqfp_pkg::IDX_PENB);
  assign wr_ppra = rif.wr_en && (rif.wr_idx == irqfp_pkg::IDX_PPRA);
  assign wr_pprb = rif.wr_en && (rif.wr_idx == irqfp_pkg::IDX_PPRB);

  // external pins: two-stage synchroniser, then edge detect on stage two
  assign edge_sel = {ectl_q[irqfp_pkg::EDGE2], ectl_q[irqfp_pkg::EDGE1],
                     ectl_q[irqfp_pkg::EDGE0]};
  for (genvar i = 0; i < irqfp_pkg::EXT_N; i++) begin : g_ext
    logic s1_q, s2_q, prev_q;
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        s1_q <= 1'b0;
        s2_q <= 1'b0;
        prev_q <= 1'b0;
      end else begin
        s1_q <= ext_pin[i];
        s2_q <= s1_q;
        prev_q <= s2_q;
      end
    end
    assign ext_evt[i] = edge_sel[i] ? (s2_q && !prev_q) : (!s2_q && prev_q);
  end

  // pull-ups follow the latch unless globally disabled
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      portb_pullup_en <= '0;
    end else begin
      portb_pullup_en <= ectl_q[irqfp_pkg::PULLUP_DIS] ? '0 : portb_latch;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ectl_q <= irqfp_pkg::RST_ECTL;
    end else if (wr_ectl) begin
      ectl_q <= rif.wr_data & irqfp_pkg::MASK_ECTL;
    end
  end

  // flags: a hardware event ORs in after the write, so set beats clear
  always_comb begin
    xset = '0;
    xset[irqfp_pkg::X1_FLAG] = ext_evt[1];
    xset[irqfp_pkg::X2_FLAG] = ext_evt[2];
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      xctl_q <= irqfp_pkg::RST_XCTL;
    end else begin
      xctl_q <= ((wr_xctl ? rif.wr_data : xctl_q) | xset) & irqfp_pkg::MASK_XCTL;
    end
  end

  // reset-status bits are plain storage here; reserved bits never stick
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rctl_q <= irqfp_pkg::RST_RCTL;
    end else if (wr_rctl) begin
      rctl_q <= rif.wr_data & irqfp_pkg::MASK_RCTL;
    end
  end
  assign prio_on = rctl_q[irqfp_pkg::PRIO_ON];

  always_comb begin
    pfa_set = '0;
    pfa_set[irqfp_pkg::AD_B] = adc_done;
    pfa_set[irqfp_pkg::SSP_B] = sync_serial_done;
    pfa_set[irqfp_pkg::CCP1_B] = ((ccp1_mode == irqfp_pkg::CCP_CAPTURE) && ccp1_capture)
                                 || ((ccp1_mode == irqfp_pkg::CCP_COMPARE) && ccp1_match);
    pfa_set[irqfp_pkg::T2_B] = timer2_match;
    pfa_set[irqfp_pkg::T1_B] = timer1_ovf;
    pfb_set = '0;
    pfb_set[irqfp_pkg::BCL_B] = bus_collision;
    pfb_set[irqfp_pkg::LVD_B] = low_voltage;
    pfb_set[irqfp_pkg::T3_B] = timer3_ovf;
    pfb_set[irqfp_pkg::CCP2_B] = ((ccp2_mode == irqfp_pkg::CCP_CAPTURE) && ccp2_capture)
                                 || ((ccp2_mode == irqfp_pkg::CCP_COMPARE) && ccp2_match);
  end

  // set regardless of any enable, so polling works
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pfa_q <= irqfp_pkg::RST_ZERO;
      pfb_q <= irqfp_pkg::RST_ZERO;
    end else begin
      pfa_q <= ((wr_pfa ? rif.wr_data : pfa_q) | pfa_set) & irqfp_pkg::WMASK_PFA;
      pfb_q <= ((wr_pfb ? rif.wr_data : pfb_q) | pfb_set) & irqfp_pkg::MASK_PFB;
    end
  end

  // serial flags mirror the buffer state and are never stored
  always_comb begin
    pfa_full = pfa_q;
    pfa_full[irqfp_pkg::RX_B] = rx_buffer_full;
    pfa_full[irqfp_pkg::TX_B] = tx_buffer_empty;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pena_q <= irqfp_pkg::RST_ZERO;
      penb_q <= irqfp_pkg::RST_ZERO;
      ppra_q <= irqfp_pkg::RST_PPRA;
      pprb_q <= irqfp_pkg::RST_PPRB;
    end else begin
      if (wr_pena) pena_q <= rif.wr_data & irqfp_pkg::MASK_PFA;
      if (wr_penb) penb_q <= rif.wr_data & irqfp_pkg::MASK_PFB;
      if (wr_ppra) ppra_q <= rif.wr_data & irqfp_pkg::MASK_PFA;
      if (wr_pprb) pprb_q <= rif.wr_data & irqfp_pkg::MASK_PFB;
    end
  end

  // acceptance clears the enable after the write, so it cannot be lost
  assign accept = irq_ack && irq_req_q;
  always_comb begin
    core_d = wr_core ? rif.wr_data : core_q;
    core_d[irqfp_pkg::X0_FLAG] = core_d[irqfp_pkg::X0_FLAG] | ext_evt[0];
    if (accept && irq_high_q) begin
      core_d[irqfp_pkg::GLB_EN] = 1'b0;
    end else if (accept) begin
      core_d[irqfp_pkg::GRP_EN] = 1'b0;
    end
    core_d = core_d & irqfp_pkg::MASK_CORE;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      core_q <= irqfp_pkg::RST_ZERO;
    end else begin
      core_q <= core_d;
    end
  end

  assign ext_pend[0] = core_q[irqfp_pkg::X0_FLAG] && core_q[irqfp_pkg::X0_EN];
  assign ext_pend[1] = xctl_q[irqfp_pkg::X1_FLAG] && xctl_q[irqfp_pkg::X1_EN];
  assign ext_pend[2] = xctl_q[irqfp_pkg::X2_FLAG] && xctl_q[irqfp_pkg::X2_EN];
  assign core_pend = {port_change_req, timer0_ovf_req, ext_pend};
  // external 0 has no priority bit and is always high
  assign core_prio = {ectl_q[irqfp_pkg::PC_PRIO], ectl_q[irqfp_pkg::T0_PRIO],
                      xctl_q[irqfp_pkg::X2_PRIO], xctl_q[irqfp_pkg::X1_PRIO], 1'b1};
  assign per_pend = {penb_q & pfb_q, pena_q & pfa_full};
  assign per_prio = {pprb_q, ppra_q};
  assign hi_any = |(core_pend & core_prio) || |(per_pend & per_prio);
  assign lo_any = |(core_pend & ~core_prio) || |(per_pend & ~per_prio);

  // levels off: bit 7 is the single enable, bit 6 only gates peripherals
  always_comb begin
    if (prio_on) begin
      req_hi = core_q[irqfp_pkg::GLB_EN] && hi_any;
      req_lo = core_q[irqfp_pkg::GRP_EN] && lo_any;
    end else begin
      req_hi = core_q[irqfp_pkg::GLB_EN]
               && (|core_pend || (core_q[irqfp_pkg::GRP_EN] && |per_pend));
      req_lo = 1'b0;
    end
  end

  // request drops right after acceptance, before the cleared enable shows
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_req_q <= 1'b0;
      irq_high_q <= 1'b0;
      irq_vector_q <= irqfp_pkg::VEC_HIGH;
    end else begin
      irq_req_q <= (req_hi || req_lo) && !accept;
      irq_high_q <= req_hi;
      irq_vector_q <= req_hi ? irqfp_pkg::VEC_HIGH : irqfp_pkg::VEC_LOW;
    end
  end
  assign irq_req = irq_req_q;
  assign irq_high = irq_high_q;
  assign irq_vector = irq_vector_q;

  always_comb begin
    case (rif.rd_idx)
      irqfp_pkg::IDX_ECTL: rif.rd_data = ectl_q;
      irqfp_pkg::IDX_XCTL: rif.rd_data = xctl_q;
      irqfp_pkg::IDX_RCTL: rif.rd_data = rctl_q;
      irqfp_pkg::IDX_PFA: rif.rd_data = pfa_full;
      irqfp_pkg::IDX_PFB: rif.rd_data = pfb_q;
      irqfp_pkg::IDX_CORE: rif.rd_data = core_q;
      irqfp_pkg::IDX_PENA: rif.rd_data = pena_q;
      irqfp_pkg::IDX_PENB: rif.rd_data = penb_q;
      irqfp_pkg::IDX_PPRA: rif.rd_data = ppra_q;
      irqfp_pkg::IDX_PPRB: rif.rd_data = pprb_q;
      default: rif.rd_data = irqfp_pkg::RST_ZERO;
    endcase
  end

  AST_PULLUP_OFF: assert property (@(posedge aclk) disable iff (!aresetn)
    ectl_q[irqfp_pkg::PULLUP_DIS] |=> (portb_pullup_en == 8'h00))
    else $error("pull-up on while disabled");

  AST_EXT1_EDGE: assert property (@(posedge aclk) disable iff (!aresetn)
    (g_ext[1].s2_q != g_ext[1].prev_q) && (g_ext[1].s2_q == edge_sel[1])
    |=> xctl_q[irqfp_pkg::X1_FLAG])
    else $error("ext1 edge did not set its flag");

  AST_FLAG_NO_ENABLE: assert property (@(posedge aclk) disable iff (!aresetn)
    (ext_evt[2] && !xctl_q[irqfp_pkg::X2_EN]) |=> xctl_q[irqfp_pkg::X2_FLAG])
    else $error("disabled ext2 flag not set");

  AST_SET_WINS: assert property (@(posedge aclk) disable iff (!aresetn)
    (adc_done && wr_pfa && !rif.wr_data[irqfp_pkg::AD_B]) |=> pfa_q[irqfp_pkg::AD_B])
    else $error("converter flag lost to a clear");

  AST_UNIMP_ZERO: assert property (@(posedge aclk) disable iff (!aresetn)
    ((xctl_q & ~irqfp_pkg::MASK_XCTL) == 8'h00) && ((rctl_q & ~irqfp_pkg::MASK_RCTL) == 8'h00))
    else $error("unimplemented bit is set");

  AST_NO_GROUP: assert property (@(posedge aclk) disable iff (!aresetn)
    (!prio_on && !core_q[irqfp_pkg::GRP_EN] && (core_pend == 5'h00)) |=> !irq_req)
    else $error("peripheral request without group enable");

  AST_COMPAT_VEC: assert property (@(posedge aclk) disable iff (!aresetn)
    (irq_req && !$past(prio_on)) |-> (irq_high && irq_vector == irqfp_pkg::VEC_HIGH))
    else $error("compatibility request not on high vector");

  AST_LOW_VEC: assert property (@(posedge aclk) disable iff (!aresetn)
    (irq_req && !irq_high) |-> (irq_vector == irqfp_pkg::VEC_LOW))
    else $error("low request on wrong vector");

  AST_ACK_CLEAR: assert property (@(posedge aclk) disable iff (!aresetn)
    (irq_ack && irq_req) |=> (!irq_req
    && !(($past(irq_high) ? core_q[irqfp_pkg::GLB_EN] : core_q[irqfp_pkg::GRP_EN]))))
    else $error("acceptance left its enable set");

  // a low request can only come from a cycle with levels enabled
  AST_LOW_LEVELS: assert property (@(posedge aclk) disable iff (!aresetn)
    (irq_req && !irq_high) |-> $past(prio_on))
    else $error("low request while levels off");

  AST_EXT1_HOLD: assert property (@(posedge aclk) disable iff (!aresetn)
    (xctl_q[irqfp_pkg::X1_FLAG] && !wr_xctl) |=> xctl_q[irqfp_pkg::X1_FLAG])
    else $error("ext1 flag dropped without a write");

  AST_COLL_HOLD: assert property (@(posedge aclk) disable iff (!aresetn)
    (pfb_q[irqfp_pkg::BCL_B] && !wr_pfb) |=> pfb_q[irqfp_pkg::BCL_B])
    else $error("collision flag dropped without a write");

  AST_PWM_IDLE: assert property (@(posedge aclk) disable iff (!aresetn)
    ((ccp2_mode == irqfp_pkg::CCP_PWM) && !wr_pfb && !pfb_q[irqfp_pkg::CCP2_B])
    |=> !pfb_q[irqfp_pkg::CCP2_B])
    else $error("unit-2 flag set in pwm mode");

  AST_RX_MIRROR: assert property (@(posedge aclk) disable iff (!aresetn)
    (rif.rd_idx == irqfp_pkg::IDX_PFA) |-> (rif.rd_data[irqfp_pkg::RX_B] == rx_buffer_full))
    else $error("receive flag does not follow the buffer");
endmodule
`default_nettype wire

// *** tb/irqfp_core_model.sv ***
// irqfp_core_model: core side that accepts vectored requests
// assumes irq_req is a registered level on aclk
`timescale 1ns/1ps
`default_nettype none
module irqfp_core_model (
  input wire logic aclk, // system clock
  input wire logic aresetn, // sync reset, low
  input wire logic [3:0] ack_dly, // wait before accepting
  input wire logic irq_req, // request from the block
  output logic irq_ack // accept pulse
);
  logic [3:0] cnt_q;
  always_ff @(posedge aclk) begin
    if (!aresetn || !irq_req || irq_ack) begin
      cnt_q <= 4'h0;
      irq_ack <= 1'h0;
    end else begin
      cnt_q <= cnt_q + 4'h1;
      irq_ack <= cnt_q == ack_dly; // prompt or slow accept
    end
  end
endmodule
`default_nettype wire

// *** tb/irqfp_top_test.sv ***
// irqfp_top_test: register, flag, pin, pull-up and vector scenarios
// assumes irqfp_core_model stands in for the core
`timescale 1ns/1ps
`default_nettype none
module irqfp_top_test;
  logic aclk, aresetn, awv, awr, wv, wrd, bv, br, arv, arr, rv, rr, rx, tx, t0, pc, ack, req, hi;
  logic [7:0] awaddr, araddr, latch, pull, pa, pb;
  logic [31:0] wdata, rdata;
  logic [1:0] bresp, rresp;
  logic [2:0] pin;
  logic [3:0] dly;
  logic [20:0] vec;
  int n_fail, cmp_count;
  irqfp_pkg::irqfp_ccp_mode_type m1, m2;
  irqfp_top DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv),
    .s_axi_wready(wrd), .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(br),
    .s_axi_araddr(araddr), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rr), .ext_pin(pin),
    .portb_latch(latch), .portb_pullup_en(pull), .timer0_ovf_req(t0), .port_change_req(pc),
    .adc_done(pa[6]), .rx_buffer_full(rx), .tx_buffer_empty(tx), .sync_serial_done(pa[3]),
    .ccp1_mode(m1), .ccp1_capture(pa[2]), .ccp1_match(pa[7]),
    .timer2_match(pa[1]), .timer1_ovf(pa[0]), .bus_collision(pb[3]), .low_voltage(pb[2]),
    .timer3_ovf(pb[1]), .ccp2_mode(m2), .ccp2_capture(pb[0]),
    .ccp2_match(pb[7]), .irq_ack(ack), .irq_req(req), .irq_high(hi), .irq_vector(vec));
  irqfp_core_model core (.aclk(aclk), .aresetn(aresetn), .ack_dly(dly), .irq_req(req),
    .irq_ack(ack));
  task automatic chk(input string s, input logic [33:0] e, input logic [33:0] g);
    cmp_count++;
    if (g !== e) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic wr(input logic [5:0] i, input logic [7:0] d);
    awaddr <= {i, 2'h0};
    wdata <= {24'h0, d};
    awv <= 1'h1;
    wv <= 1'h1;
    do begin
      @(posedge aclk);
      if (awr && awv) awv <= 1'h0;
      if (wrd && wv) wv <= 1'h0;
    end while (bv !== 1'h1);
    chk("bresp", 34'h0, {32'h0, bresp});
  endtask
  task automatic rc(input logic [5:0] i, input logic [7:0] e);
    araddr <= {i, 2'h0};
    arv <= 1'h1;
    do begin
      @(posedge aclk);
      if (arr) arv <= 1'h0;
    end while (rv !== 1'h1);
    chk("reg", {(i > 6'h09) ? irqfp_pkg::RESP_SLVERR : irqfp_pkg::RESP_OKAY, 24'h0, e},
      {rresp, rdata});
  endtask
  task automatic t_regs;
    rc(irqfp_pkg::IDX_ECTL, 8'hF5);
    rc(irqfp_pkg::IDX_XCTL, 8'hC0);
    rc(irqfp_pkg::IDX_RCTL, 8'h1C);
    rc(irqfp_pkg::IDX_PFA, 8'h10);
    rc(6'h0A, 8'h00);
    wr(irqfp_pkg::IDX_XCTL, 8'hFF);
    rc(irqfp_pkg::IDX_XCTL, 8'hDB);
    wr(irqfp_pkg::IDX_XCTL, 8'h00);
  endtask
  task automatic t_flags;
    pa <= 8'hCF;
    pb <= 8'h8F;
    @(posedge aclk);
    pa <= 8'h00;
    pb <= 8'h00;
    rc(irqfp_pkg::IDX_PFA, 8'h5F);
    rc(irqfp_pkg::IDX_PFB, 8'h0F);
    pa <= 8'h40;
    wr(irqfp_pkg::IDX_PFA, 8'h00);
    wr(irqfp_pkg::IDX_PFB, 8'h00);
    m1 <= irqfp_pkg::CCP_COMPARE;
    m2 <= irqfp_pkg::CCP_PWM;
    pa <= 8'h80;
    pb <= 8'h81;
    rx <= 1'h1;
    tx <= 1'h0;
    @(posedge aclk);
    pa <= 8'h00;
    pb <= 8'h00;
    rc(irqfp_pkg::IDX_PFA, 8'h64);
    rc(irqfp_pkg::IDX_PFB, 8'h00);
    wr(irqfp_pkg::IDX_PFA, 8'h00);
    rc(irqfp_pkg::IDX_PFA, 8'h20);
    rx <= 1'h0;
    tx <= 1'h1;
  endtask
  task automatic t_pins;
    pin <= 3'h6;
    repeat (5) @(posedge aclk);
    rc(irqfp_pkg::IDX_XCTL, 8'h03);
    wr(irqfp_pkg::IDX_ECTL, 8'hE5);
    wr(irqfp_pkg::IDX_XCTL, 8'h00);
    pin <= 3'h1;
    repeat (5) @(posedge aclk);
    rc(irqfp_pkg::IDX_XCTL, 8'h02);
    rc(irqfp_pkg::IDX_CORE, 8'h02);
    wr(irqfp_pkg::IDX_XCTL, 8'h00);
    wr(irqfp_pkg::IDX_CORE, 8'h00);
  endtask
  task automatic t_pull;
    chk("pullup", 34'h0, {26'h0, pull});
    wr(irqfp_pkg::IDX_ECTL, 8'h65);
    repeat (2) @(posedge aclk);
    chk("pullup", 34'h5A, {26'h0, pull});
  endtask
  task automatic t_vec(input logic [7:0] rctl, core_en, input logic [21:0] e, input logic [3:0] d);
    wr(irqfp_pkg::IDX_RCTL, rctl);
    dly <= d;
    wr(irqfp_pkg::IDX_CORE, core_en);
    wr(irqfp_pkg::IDX_XCTL, 8'h09);
    while (req !== 1'h1) @(posedge aclk);
    chk("vector", {12'h0, e}, {12'h0, hi, vec});
    while (req !== 1'h0) @(posedge aclk);
    rc(irqfp_pkg::IDX_CORE, 8'h00);
    wr(irqfp_pkg::IDX_XCTL, 8'h00);
  endtask
  task automatic t_prio;
    wr(irqfp_pkg::IDX_CORE, 8'h80);
    t0 <= 1'h1;
    while (req !== 1'h1) @(posedge aclk);
    chk("vector", {12'h0, 1'h1, irqfp_pkg::VEC_HIGH}, {12'h0, hi, vec});
    while (req !== 1'h0) @(posedge aclk);
    t0 <= 1'h0;
    wr(irqfp_pkg::IDX_ECTL, 8'h64);
    wr(irqfp_pkg::IDX_CORE, 8'h40);
    pc <= 1'h1;
    while (req !== 1'h1) @(posedge aclk);
    chk("vector", {12'h0, 1'h0, irqfp_pkg::VEC_LOW}, {12'h0, hi, vec});
    while (req !== 1'h0) @(posedge aclk);
    pc <= 1'h0;
    rc(irqfp_pkg::IDX_CORE, 8'h00);
  endtask
  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    aclk = 1'h0;
    forever #2.5 aclk = ~aclk;
  end
  initial begin
    {aresetn, awv, wv, arv, t0, pc, rx, pa, pb, pin, awaddr, araddr, wdata} = '0;
    {br, rr, tx} = 3'h7;
    m1 = irqfp_pkg::CCP_CAPTURE;
    m2 = irqfp_pkg::CCP_CAPTURE;
    latch = 8'h5A;
    dly = 4'h1;
    n_fail = 0;
    cmp_count = 0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    t_regs();
    t_flags();
    t_pins();
    t_pull();
    t_vec(8'h1C, 8'h80, {1'h1, irqfp_pkg::VEC_HIGH}, 4'h1);
    t_vec(8'h9C, 8'h40, {1'h0, irqfp_pkg::VEC_LOW}, 4'h6);
    t_prio();
    stop_test();
  end
  initial begin
    repeat (4000) @(posedge aclk);
    n_fail++;
    stop_test();
  end
endmodule
`default_nettype wire
